// *** core/rfm_regs.vh ***
// Purpose: Constants for the resolver fault monitor
// Assumes: Register index times four gives the byte address
// Notes: Config registers hold seven data bits and even parity in bit 7
`ifndef RFM_REGS_VH
`define RFM_REGS_VH
`define RFM_IDX_LOSS_THR    8'h88
`define RFM_IDX_DEG_THR     8'h89
`define RFM_IDX_MIS_THR     8'h8A
`define RFM_IDX_MAX_INIT    8'h8B
`define RFM_IDX_MIN_INIT    8'h8C
`define RFM_IDX_TRK_HI_THR  8'h8D
`define RFM_IDX_TRK_LO_THR  8'h8E
`define RFM_IDX_WIN_SEL     8'h90
`define RFM_IDX_FAULT       8'hFF
`define RFM_RST_LOSS_THR    8'h00
`define RFM_RST_DEG_THR     8'hFF
`define RFM_RST_MIS_THR     8'hFF
`define RFM_RST_MAX_INIT    8'h00
`define RFM_RST_MIN_INIT    8'hFF
`define RFM_RST_TRK_HI_THR  8'hFF
`define RFM_RST_TRK_LO_THR  8'h81
`define RFM_RST_WIN_SEL     8'h03
`define RFM_FB_PARITY       0
`define RFM_FB_PHASE        1
`define RFM_FB_OVERSPEED    2
`define RFM_FB_TRK_ERR      3
`define RFM_FB_MISMATCH     4
`define RFM_FB_OVERRANGE    5
`define RFM_FB_LOSS         6
`define RFM_FB_CLIP         7
`define RFM_WIN_LOW_CYC     11'd1065
`define RFM_WIN_MID_CYC     11'd554
`define RFM_WIN_HIGH_CYC    11'd256
`define RFM_CLK_PERIOD_NS   10
`define RFM_CLIP_TIME_NS    4000
`define RFM_CLIP_CYC        (`RFM_CLIP_TIME_NS / `RFM_CLK_PERIOD_NS)
`define RFM_RESP_OKAY       2'b00
`define RFM_RESP_DECERR     2'b11
`endif

// *** core/rfm_monitor.v ***
// Purpose: Fault supervision for a resolver-to-digital converter
// Assumes: Magnitudes, angle error and overspeed come from logic on aclk
// Notes: Clip comparator levels arrive from pins and are synchronised
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rfm_regs.vh"

//Contract
// - Low minimum magnitude latches both pins low
// - High maximum magnitude flags degradation
// - Max minus min over threshold flags mismatch
// - Degradation latches its pin until cleared
// - Internal tick is clock divided by two
// - Window lasts 1065, 554 or 256 ticks
// - Window end compares min and max thresholds
// - Crossing reported within two windows
// - Persistent fault returns within one window
// - Error above high threshold loses tracking
// - Overspeed also loses tracking
// - Tracking loss clears below low threshold
// - Overspeed clears needing speed and error low
// - Pins encode highest priority fault
// - Each condition has its own fault bit
// - Clip over four microseconds raises fault
// - Clip sets bit 7, latches both pins
// - Registers carry parity bit, checked continuously
// - Parity error sets bit 0, latches pins
// - Phase lock error drives tracking pin, bit 1
module rfm_monitor #(
    parameter ADDR_W   = 10,
    parameter CLIP_CYC = `RFM_CLIP_CYC
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              clk_en,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              config_mode,
    input  wire [6:0]        monitor_mag,
    input  wire [6:0]        angle_error,
    input  wire              overspeed,
    input  wire              phase_lock_err,
    input  wire [3:0]        clip_pins,
    output reg               signal_degraded_n,
    output reg               tracking_lost_n
);
    reg  [7:0]  loss_threshold;
    reg  [7:0]  degradation_threshold;
    reg  [7:0]  mismatch_threshold;
    reg  [7:0]  monitor_max_initial;
    reg  [7:0]  monitor_min_initial;
    reg  [7:0]  tracking_error_high_threshold;
    reg  [7:0]  tracking_error_low_threshold;
    reg  [7:0]  window_select;
    reg  [7:0]  fault_flags;
    reg         tick;
    reg  [10:0] win_cnt;
    reg  [1:0]  win_sel_seen;
    reg  [6:0]  mag_min;
    reg  [6:0]  mag_max;
    reg         signal_lost;
    reg         degraded;
    reg         trk_err_lost;
    reg         trk_speed_lost;
    reg  [7:0]  next_fault;
    reg  [31:0] next_rdata;
    reg         rd_hit;
    reg  [10:0] win_len;
    reg  [1:0]  next_pin_code;
    reg         wr_hit;
    wire [63:0] cfg_bus;
    wire [7:0]  cfg_par;

    localparam PIN_NONE = 2'b00;
    localparam PIN_TRK  = 2'b01;
    localparam PIN_DEG  = 2'b10;
    localparam PIN_LOSS = 2'b11;
    wire [7:0]  wr_idx = s_axi_awaddr[9:2];
    wire [7:0]  rd_idx = s_axi_araddr[9:2];
    wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;
    wire        wr_en = wr_go & s_axi_wstrb[0];
    wire        win_end;
    wire        fault_clr;
    wire        parity_err;
    wire        mismatch;
    wire [3:0]  clip_long;
    wire        tracking_lost;

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    // Reading the fault register in configuration mode clears it
    assign fault_clr = clk_en & rd_go & config_mode & (rd_idx == `RFM_IDX_FAULT);

    // Config registers side by side for the parity check
    assign cfg_bus = {window_select, tracking_error_low_threshold,
                      tracking_error_high_threshold, monitor_min_initial,
                      monitor_max_initial, mismatch_threshold,
                      degradation_threshold, loss_threshold};

    // Even parity per config register
    genvar p;
    generate
        for (p = 0; p < 8; p = p + 1) begin : g_par
            assign cfg_par[p] = ^cfg_bus[8*p+7:8*p];
        end
    endgenerate

    assign parity_err = |cfg_par;

    // Clip filter per input pin
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_clip
            reg [2:0]  sync;
            reg        level;
            reg [15:0] run;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    sync  <= 3'h0;
                    level <= 1'b0;
                    run   <= 16'h0000;
                end else if (clk_en) begin
                    sync <= {sync[1:0], clip_pins[g]};
                    if (sync[1] == sync[2])
                        level <= sync[2];
                    if (!level)
                        run <= 16'h0000;
                    else if (run <= CLIP_CYC[15:0])
                        run <= run + 16'h0001;
                end
            end
            assign clip_long[g] = run > CLIP_CYC[15:0];
        end
    endgenerate

    // Window length by excitation band
    always @* begin
        case (window_select[1:0])
            2'b00:   win_len = `RFM_WIN_LOW_CYC;
            2'b01:   win_len = `RFM_WIN_MID_CYC;
            default: win_len = `RFM_WIN_HIGH_CYC;
        endcase
    end

    assign win_end  = tick & (win_cnt == 11'd1);
    assign mismatch = (mag_max > mag_min) &&
                      ((mag_max - mag_min) > mismatch_threshold[6:0]);

    // Internal tick, window counter and min/max tracking
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick         <= 1'b0;
            win_cnt      <= `RFM_WIN_HIGH_CYC;
            win_sel_seen <= 2'b11;
            mag_min      <= 7'h7F;
            mag_max      <= 7'h00;
        end else if (clk_en) begin
            tick         <= ~tick;
            win_sel_seen <= window_select[1:0];
            if (win_sel_seen != window_select[1:0])
                win_cnt <= win_len;
            else if (tick)
                win_cnt <= win_end ? win_len : win_cnt - 11'd1;
            if (win_end) begin
                mag_min <= monitor_min_initial[6:0];
                mag_max <= monitor_max_initial[6:0];
            end else if (tick) begin
                if (monitor_mag < mag_min)
                    mag_min <= monitor_mag;
                if (monitor_mag > mag_max)
                    mag_max <= monitor_mag;
            end
        end
    end

    // Fault flags: hardware set wins over read clear
    always @* begin
        next_fault = fault_clr ? 8'h00 : fault_flags;
        if (win_end && (mag_min < loss_threshold[6:0]))
            next_fault[`RFM_FB_LOSS] = 1'b1;
        if (win_end && (mag_max > degradation_threshold[6:0]))
            next_fault[`RFM_FB_OVERRANGE] = 1'b1;
        if (mismatch)
            next_fault[`RFM_FB_MISMATCH] = 1'b1;
        if (trk_err_lost)
            next_fault[`RFM_FB_TRK_ERR] = 1'b1;
        if (trk_speed_lost)
            next_fault[`RFM_FB_OVERSPEED] = 1'b1;
        if (phase_lock_err)
            next_fault[`RFM_FB_PHASE] = 1'b1;
        if (|clip_long)
            next_fault[`RFM_FB_CLIP] = 1'b1;
        if (parity_err)
            next_fault[`RFM_FB_PARITY] = 1'b1;
    end

    assign tracking_lost = trk_err_lost | trk_speed_lost | phase_lock_err;

    // Latched pin causes and hysteretic tracking loss
    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_flags    <= 8'h00;
            signal_lost    <= 1'b0;
            degraded       <= 1'b0;
            trk_err_lost   <= 1'b0;
            trk_speed_lost <= 1'b0;
        end else if (clk_en) begin
            fault_flags <= next_fault;
            if (next_fault[`RFM_FB_LOSS] | next_fault[`RFM_FB_CLIP]
                    | next_fault[`RFM_FB_PARITY])
                signal_lost <= 1'b1;
            else if (fault_clr)
                signal_lost <= 1'b0;
            if (next_fault[`RFM_FB_OVERRANGE] | next_fault[`RFM_FB_MISMATCH])
                degraded <= 1'b1;
            else if (fault_clr)
                degraded <= 1'b0;
            if (angle_error > tracking_error_high_threshold[6:0])
                trk_err_lost <= 1'b1;
            else if (angle_error < tracking_error_low_threshold[6:0])
                trk_err_lost <= 1'b0;
            if (overspeed)
                trk_speed_lost <= 1'b1;
            else if (angle_error < tracking_error_low_threshold[6:0])
                trk_speed_lost <= 1'b0;
        end
    end

    // Highest priority active cause picks the pin code
    always @* begin
        if (signal_lost)
            next_pin_code = PIN_LOSS;
        else if (degraded)
            next_pin_code = PIN_DEG;
        else if (tracking_lost)
            next_pin_code = PIN_TRK;
        else
            next_pin_code = PIN_NONE;
    end

    // Pin encoding by priority
    always @(posedge aclk) begin
        if (!aresetn) begin
            signal_degraded_n <= 1'b1;
            tracking_lost_n   <= 1'b1;
        end else if (clk_en) begin
            case (next_pin_code)
                PIN_LOSS: begin
                    signal_degraded_n <= 1'b0;
                    tracking_lost_n   <= 1'b0;
                end
                PIN_DEG: begin
                    signal_degraded_n <= 1'b0;
                    tracking_lost_n   <= 1'b1;
                end
                PIN_TRK: begin
                    signal_degraded_n <= 1'b1;
                    tracking_lost_n   <= 1'b0;
                end
                default: begin
                    signal_degraded_n <= 1'b1;
                    tracking_lost_n   <= 1'b1;
                end
            endcase
        end
    end

    // Register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            loss_threshold                <= `RFM_RST_LOSS_THR;
            degradation_threshold         <= `RFM_RST_DEG_THR;
            mismatch_threshold            <= `RFM_RST_MIS_THR;
            monitor_max_initial           <= `RFM_RST_MAX_INIT;
            monitor_min_initial           <= `RFM_RST_MIN_INIT;
            tracking_error_high_threshold <= `RFM_RST_TRK_HI_THR;
            tracking_error_low_threshold  <= `RFM_RST_TRK_LO_THR;
            window_select                 <= `RFM_RST_WIN_SEL;
        end else if (clk_en && wr_en) begin
            case (wr_idx)
                `RFM_IDX_LOSS_THR:   loss_threshold <= s_axi_wdata[7:0];
                `RFM_IDX_DEG_THR:    degradation_threshold <= s_axi_wdata[7:0];
                `RFM_IDX_MIS_THR:    mismatch_threshold <= s_axi_wdata[7:0];
                `RFM_IDX_MAX_INIT:   monitor_max_initial <= s_axi_wdata[7:0];
                `RFM_IDX_MIN_INIT:   monitor_min_initial <= s_axi_wdata[7:0];
                `RFM_IDX_TRK_HI_THR: tracking_error_high_threshold <= s_axi_wdata[7:0];
                `RFM_IDX_TRK_LO_THR: tracking_error_low_threshold <= s_axi_wdata[7:0];
                `RFM_IDX_WIN_SEL:    window_select <= s_axi_wdata[7:0];
                default:             window_select <= window_select;
            endcase
        end
    end

    // Write decode
    always @* begin
        case (wr_idx)
            `RFM_IDX_LOSS_THR, `RFM_IDX_DEG_THR, `RFM_IDX_MIS_THR,
            `RFM_IDX_MAX_INIT, `RFM_IDX_MIN_INIT, `RFM_IDX_TRK_HI_THR,
            `RFM_IDX_TRK_LO_THR, `RFM_IDX_WIN_SEL, `RFM_IDX_FAULT:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // Read decode
    always @* begin
        next_rdata = 32'h0000_0000;
        rd_hit     = 1'b1;
        case (rd_idx)
            `RFM_IDX_LOSS_THR:   next_rdata[7:0] = loss_threshold;
            `RFM_IDX_DEG_THR:    next_rdata[7:0] = degradation_threshold;
            `RFM_IDX_MIS_THR:    next_rdata[7:0] = mismatch_threshold;
            `RFM_IDX_MAX_INIT:   next_rdata[7:0] = monitor_max_initial;
            `RFM_IDX_MIN_INIT:   next_rdata[7:0] = monitor_min_initial;
            `RFM_IDX_TRK_HI_THR: next_rdata[7:0] = tracking_error_high_threshold;
            `RFM_IDX_TRK_LO_THR: next_rdata[7:0] = tracking_error_low_threshold;
            `RFM_IDX_WIN_SEL:    next_rdata[7:0] = window_select;
            `RFM_IDX_FAULT:      next_rdata[7:0] = fault_flags;
            default:             rd_hit = 1'b0;
        endcase
        if (s_axi_araddr[1:0] != 2'b00)
            rd_hit = 1'b0;
        if (!rd_hit)
            next_rdata = 32'h0000_0000;
    end

    // Bus responses
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RFM_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `RFM_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RFM_RESP_OKAY : `RFM_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= rd_hit ? `RFM_RESP_OKAY : `RFM_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rfm_monitor

// *** sim/rfm_monitor_asserts.sv ***
// Purpose: Port checks for the resolver fault monitor
// Assumes: clk_en held high while faults are judged
// Notes: Bound to every rfm_monitor instance
`timescale 1ns/1ns
`include "rfm_regs.vh"
module rfm_monitor_asserts #(
    parameter ADDR_W = 10
) (
    input wire              aclk,
    input wire              aresetn,
    input wire              clk_en,
    input wire              s_axi_awvalid,
    input wire              s_axi_wvalid,
    input wire              s_axi_bvalid,
    input wire              s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire              s_axi_arvalid,
    input wire              s_axi_rvalid,
    input wire [1:0]        s_axi_rresp,
    input wire [6:0]        angle_error,
    input wire              overspeed,
    input wire              phase_lock_err,
    input wire              signal_degraded_n,
    input wire              tracking_lost_n
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && clk_en |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid && clk_en |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_misalign_err: assert property (
        s_axi_arvalid && !s_axi_rvalid && clk_en && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == `RFM_RESP_DECERR)
        else $error("misaligned read not refused");
    a_phase_pin: assert property (
        phase_lock_err [*3] |-> !tracking_lost_n || !signal_degraded_n)
        else $error("phase error not shown");
    a_speed_pin: assert property (
        overspeed [*3] |-> !tracking_lost_n || !signal_degraded_n)
        else $error("overspeed not shown");
    a_track_release: assert property (
        (!overspeed && !phase_lock_err && angle_error == 7'h0 && signal_degraded_n) [*3]
        |-> tracking_lost_n)
        else $error("tracking pin stuck low");
    a_deg_latch: assert property (
        !signal_degraded_n && !s_axi_arvalid && !$past(s_axi_arvalid)
        |=> !signal_degraded_n)
        else $error("degraded pin released without read");
endmodule // rfm_monitor_asserts
bind rfm_monitor rfm_monitor_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** sim/rfm_sensor_model.sv ***
// Purpose: Resolver front end stand-in
// Assumes: Magnitudes and flags arrive on aclk
// Notes: Levels change only on the bench's command
`timescale 1ns/1ns
module rfm_sensor_model (
    input  wire        aclk,
    output logic [6:0] monitor_mag = 7'h20,
    output logic [6:0] angle_error = 7'h00,
    output logic       overspeed = 1'h0,
    output logic       phase_lock_err = 1'h0,
    output logic [3:0] clip_pins = 4'h0
);
    task set(input [6:0] m, a, input o, p, input [3:0] c);
        @(posedge aclk);
        monitor_mag <= m;
        angle_error <= a;
        overspeed <= o;
        phase_lock_err <= p;
        clip_pins <= c;
    endtask
endmodule // rfm_sensor_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the resolver fault monitor
// Assumes: Clip count shortened to 8 cycles
// Notes: Window select left at reset, 512 clocks a window
`timescale 1ns/1ns
`include "rfm_regs.vh"
module tb;
    logic        aclk = 0, aresetn = 0, clk_en = 1, config_mode = 0;
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [6:0]  m = 7'h20;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [6:0]  monitor_mag, angle_error;
    wire         overspeed, phase_lock_err, signal_degraded_n, tracking_lost_n;
    wire  [3:0]  clip_pins;
    wire  [1:0]  pn = {signal_degraded_n, tracking_lost_n};
    int          failures = 0, n_tests = 0;
    always #5 aclk = ~aclk;
    rfm_monitor #(.CLIP_CYC(8)) uut (.s_axi_wstrb(4'hF), .*);
    rfm_sensor_model pm (.*);
    task test_done;
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task ck(input [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tmo(input int k);
        if (k >= 50) begin
            failures++;
            $display("wrong value at %0t: bus wait ran out", $time);
            test_done;
        end
    endtask
    task wr(input [7:0] i, v, input [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (k = 0; k < 50 && s_axi_awready !== 1; k++) @(posedge aclk);
        tmo(k);
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        for (k = 0; k < 50 && s_axi_bvalid !== 1; k++) @(posedge aclk);
        tmo(k);
        s_axi_bready <= 0;
        ck(s_axi_bresp, r);
    endtask
    task rd(input [9:0] a, input [1:0] r, output [31:0] q);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (k = 0; k < 50 && s_axi_arready !== 1; k++) @(posedge aclk);
        tmo(k);
        s_axi_arvalid <= 0;
        for (k = 0; k < 50 && s_axi_rvalid !== 1; k++) @(posedge aclk);
        tmo(k);
        q = s_axi_rdata;
        s_axi_rready <= 0;
        ck(s_axi_rresp, r);
    endtask
    task fr(input [7:0] b);
        config_mode <= 1;
        rd({`RFM_IDX_FAULT, 2'h0}, 2'h0, d);
        config_mode <= 0;
        ck(d & b, b);
    endtask
    task pw(input [1:0] e, input int n);
        int k;
        for (k = 0; k < n && pn !== e; k++) @(posedge aclk);
        ck(pn, e);
    endtask
    task t_regs;
        wr(`RFM_IDX_TRK_HI_THR, 8'hA0, 2'h0);
        wr(`RFM_IDX_TRK_LO_THR, 8'h88, 2'h0);
        rd({`RFM_IDX_TRK_HI_THR, 2'h0}, 2'h0, d);
        ck(d, 32'hA0);
        rd({`RFM_IDX_DEG_THR, 2'h0}, 2'h0, d);
        ck(d, 32'hFF);
        wr(8'h80, 8'h01, `RFM_RESP_DECERR);
        rd(10'h235, `RFM_RESP_DECERR, d);
        ck(d, 32'h0);
    endtask
    task t_track;
        pm.set(m, 7'h21, 0, 0, 4'h0);
        pw(2'h2, 6);
        pm.set(m, 7'h10, 0, 0, 4'h0);
        repeat (10) @(posedge aclk);
        ck(pn, 2'h2);
        pm.set(m, 7'h04, 0, 0, 4'h0);
        pw(2'h3, 6);
        pm.set(m, 7'h10, 1, 0, 4'h0);
        pw(2'h2, 6);
        pm.set(m, 7'h10, 0, 0, 4'h0);
        repeat (10) @(posedge aclk);
        ck(pn, 2'h2);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        pw(2'h3, 6);
        pm.set(m, 7'h00, 0, 1, 4'h0);
        pw(2'h2, 6);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        pw(2'h3, 6);
        fr(8'h0E);
    endtask
    task t_deg;
        wr(`RFM_IDX_DEG_THR, 8'h30, 2'h0);
        pm.set(7'h40, 7'h21, 0, 0, 4'h0);
        pw(2'h1, 1100);
        pm.set(7'h40, 7'h00, 0, 0, 4'h0);
        fr(8'h28);
        pw(2'h3, 5);
        pw(2'h1, 600);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        repeat (600) @(posedge aclk);
        ck(pn, 2'h1);
        fr(8'h20);
        pw(2'h3, 5);
        repeat (1100) @(posedge aclk);
        ck(pn, 2'h3);
    endtask
    task t_mis;
        wr(`RFM_IDX_MIS_THR, 8'h05, 2'h0);
        pm.set(7'h30, 7'h00, 0, 0, 4'h0);
        repeat (4) @(posedge aclk);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        pw(2'h1, 20);
        wr(`RFM_IDX_MIS_THR, 8'hFF, 2'h0);
        fr(8'h10);
        pw(2'h3, 5);
    endtask
    task t_loss;
        wr(`RFM_IDX_LOSS_THR, 8'h90, 2'h0);
        wr(`RFM_IDX_MIN_INIT, 8'hFF, 2'h0);
        wr(`RFM_IDX_MAX_INIT, 8'h00, 2'h0);
        pm.set(7'h05, 7'h00, 0, 0, 4'h0);
        pw(2'h0, 1100);
        rd({`RFM_IDX_FAULT, 2'h0}, 2'h0, d);
        ck(d & 32'h40, 32'h40);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        repeat (600) @(posedge aclk);
        ck(pn, 2'h0);
        fr(8'h40);
        pw(2'h3, 5);
    endtask
    task t_clip;
        pm.set(m, 7'h00, 0, 0, 4'h2);
        repeat (5) @(posedge aclk);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        repeat (10) @(posedge aclk);
        ck(pn, 2'h3);
        pm.set(m, 7'h00, 0, 0, 4'h8);
        pw(2'h0, 30);
        pm.set(m, 7'h00, 0, 0, 4'h0);
        repeat (8) @(posedge aclk);
        fr(8'h80);
        pw(2'h3, 5);
    endtask
    task t_par;
        wr(`RFM_IDX_TRK_HI_THR, 8'h20, 2'h0);
        pw(2'h0, 6);
        fr(8'h01);
        aresetn <= 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        ck(pn, 2'h3);
        rd({`RFM_IDX_TRK_HI_THR, 2'h0}, 2'h0, d);
        ck(d, 32'hFF);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        ck(pn, 2'h3);
        t_regs;
        t_track;
        t_deg;
        t_mis;
        t_loss;
        t_clip;
        t_par;
        test_done;
    end
endmodule // tb
